// ===== ccp_pkg.sv
// Shared constants, field layouts and types for the codec clock and initialisation block.
package ccp_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int PIN_COUNT = 7;
  localparam int PIN_INDEX_W = 3;
  localparam int PERIOD_W = 10;
  localparam int INIT_CNT_W = 24;

  localparam logic [ADDR_W-1:0] ADDR_CLOCK_CONTROL = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_SYNTH_DEN_HIGH = 16'h0001;
  localparam logic [ADDR_W-1:0] ADDR_SYNTH_DEN_LOW = 16'h0002;
  localparam logic [ADDR_W-1:0] ADDR_SYNTH_NUM_HIGH = 16'h0003;
  localparam logic [ADDR_W-1:0] ADDR_SYNTH_NUM_LOW = 16'h0004;
  localparam logic [ADDR_W-1:0] ADDR_SYNTH_CONFIG = 16'h0005;
  localparam logic [ADDR_W-1:0] ADDR_SYNTH_LOCK_STATUS = 16'h0006;
  localparam logic [ADDR_W-1:0] ADDR_CLOCK_OUTPUT_CONTROL = 16'h0007;
  localparam logic [ADDR_W-1:0] ADDR_DSP_EXECUTE_CONTROL = 16'h0009;
  localparam logic [ADDR_W-1:0] ADDR_PIN_MODE_FIRST = 16'h0038;
  localparam logic [ADDR_W-1:0] ADDR_PIN_MODE_LAST = 16'h003e;

  localparam logic [DATA_W-1:0] CLOCK_CONTROL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CLOCK_CONTROL_MASK = 8'h8f;
  localparam logic [DATA_W-1:0] SYNTH_BYTE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] SYNTH_CONFIG_MASK = 8'h7f;
  localparam logic [DATA_W-1:0] CLOCK_OUTPUT_RESET = 8'h01;
  localparam logic [DATA_W-1:0] CLOCK_OUTPUT_MASK = 8'h0f;
  localparam logic [DATA_W-1:0] DSP_EXECUTE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DSP_EXECUTE_MASK = 8'h01;
  localparam logic [DATA_W-1:0] PIN_MODE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] PIN_MODE_MUTE_DACS = 8'h0b;

  localparam logic [2:0] DERIVED_CLOCK_OUTPUT_TIMES_TWO = 3'h0;
  localparam logic [2:0] DERIVED_CLOCK_OUTPUT_TIMES_ONE = 3'h1;
  localparam logic [2:0] DERIVED_CLOCK_OUTPUT_HALF = 3'h2;
  localparam logic [2:0] DERIVED_CLOCK_OUTPUT_QUARTER = 3'h3;
  localparam logic [2:0] DERIVED_CLOCK_OUTPUT_THIRD = 3'h4;

  localparam int CLK_PERIOD_NS = 5;
  localparam int INIT_TIME_MS = 12;
  localparam int INIT_TIME_NS = INIT_TIME_MS * 1000000;
  localparam int INIT_CYCLES_DEFAULT = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_TICKS_DEFAULT = 32;

  typedef struct packed {
    logic pll_enable;
    logic [2:0] spare;
    logic clock_source_select;
    logic core_clock_divider;
    logic master_clock_divider;
    logic core_clock_enable;
  } ccp_clock_ctrl_type;

  typedef struct packed {
    logic spare;
    logic [3:0] integer_part;
    logic [1:0] input_divider;
    logic fractional_mode;
  } ccp_synth_cfg_type;

  typedef struct packed {
    logic [3:0] spare;
    logic pdm_mode;
    logic [2:0] factor;
  } ccp_derived_clock_output_ctrl_type;

  typedef enum logic [1:0] {SYNTH_OFF, SYNTH_ACQUIRE, SYNTH_LOCKED} ccp_synth_state_type;

endpackage

// ===== ccp_pin_mode_bank.sv
// Pin mode word store with registered read data and per-pin mute function flags.
`timescale 1ns/1ps
module ccp_pin_mode_bank
  import ccp_pkg::*;
#(
  parameter int DEPTH = ccp_pkg::PIN_COUNT,
  parameter int WIDTH = ccp_pkg::DATA_W
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic clear_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [ccp_pkg::PIN_INDEX_W-1:0] wr_index_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  // Read port
  input wire logic [ccp_pkg::PIN_INDEX_W-1:0] rd_index_in,
  output logic [WIDTH-1:0] rd_data_out,
  // Decoded function
  output logic [DEPTH-1:0] mute_flags_out
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [WIDTH-1:0] rd_next;
  logic [DEPTH-1:0] mute_next;

  always_comb
  begin
    rd_next = '0;
    for (int i = 0; i < DEPTH; i++)
    begin
      mem_next[i] = mem_reg[i];
      if (clear_in)
        mem_next[i] = PIN_MODE_RESET;
      else if (wr_en_in && wr_index_in == PIN_INDEX_W'(i))
        mem_next[i] = wr_data_in;
      mute_next[i] = (mem_reg[i] == PIN_MODE_MUTE_DACS);
      if (rd_index_in == PIN_INDEX_W'(i))
        rd_next = mem_reg[i];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_reg[i] <= PIN_MODE_RESET;
      rd_data_out <= '0;
      mute_flags_out <= '0;
    end
    else
    begin
      mem_reg <= mem_next;
      rd_data_out <= rd_next;
      mute_flags_out <= mute_next;
    end
  end

endmodule

// ===== ccp_clock_top.sv
// Clock generation, synthesiser lock, power-up release and control registers of the codec.
//
// Notes on behaviour
// - Divider fields stay fixed; source select may switch while the core runs.
// - Both divider fields at one pass the source clock undivided.
// - Both divider fields at zero divide the source clock by two.
// - After power-up the device holds internal reset for 12 ms.
// - Core clock enable resets off; while off the master clock stays gated.
// - Lock status is readable; host enables the core only after lock.
// - Synthesiser derives the clock from references between 8 and 27 MHz.
// - Reference is first divided by the input divider field plus one.
// - Integer mode: output equals divided reference times integer over two.
// - Fractional mode: output is divided reference times (R plus N/M) over two.
// - Derived clock output gives master clock times 2, 1, 1/2, 1/4 or 1/3.
// - PDM mode allows only the divided settings; times two needs the halved source.
// - Power-down pin low powers down all circuits; host mutes beforehand.
// - A multipurpose pin set to the mute function mutes both DACs.
`timescale 1ns/1ps
module ccp_clock_top
  import ccp_pkg::*;
#(
  parameter int INIT_CYCLES = ccp_pkg::INIT_CYCLES_DEFAULT,
  parameter int LOCK_TICKS = ccp_pkg::LOCK_TICKS_DEFAULT
)
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // Control port
  input wire logic REG_WRITE_IN,
  input wire logic REG_READ_IN,
  input wire logic [ccp_pkg::ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [ccp_pkg::DATA_W-1:0] REG_WDATA_IN,
  output logic [ccp_pkg::DATA_W-1:0] REG_RDATA_OUT,
  output logic REG_RVALID_OUT,
  // Device pins
  input wire logic REFERENCE_CLOCK_INPUT_IN,
  input wire logic POWER_DOWN_PIN_N_IN,
  input wire logic [ccp_pkg::PIN_COUNT-1:0] MP_PIN_IN,
  // Clocks and status
  output logic MASTER_CLOCK_OUT,
  output logic CORE_CLOCK_OUT,
  output logic DERIVED_CLOCK_OUTPUT_OUT,
  output logic INTERNAL_READY_OUT,
  output logic SYNTH_LOCK_OUT,
  output logic DSP_RUN_OUT,
  output logic DAC_MUTE_OUT,
  output logic POWER_DOWN_OUT
);
  import ccp_pkg::*;

  logic [1:0] ref_sync_reg;
  logic [1:0] pd_sync_reg;
  logic [PIN_COUNT-1:0] mp_sync1_reg;
  logic [PIN_COUNT-1:0] mp_sync2_reg;
  logic ref_prev_reg;
  logic pd_active;
  logic ref_rise;
  logic ref_edge;

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      ref_sync_reg <= '0;
      pd_sync_reg <= '0;
      mp_sync1_reg <= '1;
      mp_sync2_reg <= '1;
      ref_prev_reg <= 1'b0;
    end
    else
    begin
      ref_sync_reg <= {ref_sync_reg[0], REFERENCE_CLOCK_INPUT_IN};
      pd_sync_reg <= {pd_sync_reg[0], POWER_DOWN_PIN_N_IN};
      mp_sync1_reg <= MP_PIN_IN;
      mp_sync2_reg <= mp_sync1_reg;
      ref_prev_reg <= ref_sync_reg[1];
    end
  end

  assign pd_active = !pd_sync_reg[1];
  assign ref_rise = ref_sync_reg[1] && !ref_prev_reg;
  assign ref_edge = ref_sync_reg[1] ^ ref_prev_reg;

  // Internal reset release and power-down.
  logic [INIT_CNT_W-1:0] init_cnt_reg, init_cnt_next;
  logic ready_reg, ready_next;

  always_comb
  begin
    init_cnt_next = init_cnt_reg;
    ready_next = ready_reg;
    if (pd_active)
    begin
      init_cnt_next = '0;
      ready_next = 1'b0;
    end
    else if (!ready_reg)
    begin
      init_cnt_next = init_cnt_reg + 1'b1;
      if (init_cnt_reg == INIT_CNT_W'(INIT_CYCLES - 1))
        ready_next = 1'b1;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      init_cnt_reg <= '0;
      ready_reg <= 1'b0;
    end
    else
    begin
      init_cnt_reg <= init_cnt_next;
      ready_reg <= ready_next;
    end
  end

  // Control registers and read path.
  ccp_clock_ctrl_type ctrl_reg, ctrl_next;
  ccp_synth_cfg_type cfg_reg, cfg_next;
  ccp_derived_clock_output_ctrl_type cko_reg, cko_next;
  logic [15:0] den_reg, den_next;
  logic [15:0] num_reg, num_next;
  logic [DATA_W-1:0] exec_reg, exec_next;
  logic [DATA_W-1:0] rdata_next;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic rd_pend_reg;
  logic locked;
  logic reg_wr;
  logic pin_wr;
  logic [DATA_W-1:0] pin_rdata;
  logic [PIN_COUNT-1:0] mute_flags;

  function automatic logic in_pin_window(input logic [ADDR_W-1:0] addr);
    return addr >= ADDR_PIN_MODE_FIRST && addr <= ADDR_PIN_MODE_LAST;
  endfunction

  function automatic logic [PIN_INDEX_W-1:0] pin_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] offset;
    offset = addr - ADDR_PIN_MODE_FIRST;
    return offset[PIN_INDEX_W-1:0];
  endfunction

  assign reg_wr = REG_WRITE_IN && ready_reg && !pd_active;
  assign pin_wr = reg_wr && in_pin_window(REG_ADDR_IN);

  ccp_pin_mode_bank #(.DEPTH(PIN_COUNT), .WIDTH(DATA_W)) u_pin_modes (
    .clk_in(CLK_IN),
    .resetn_in(RESETN_IN),
    .clear_in(pd_active),
    .wr_en_in(pin_wr),
    .wr_index_in(pin_index(REG_ADDR_IN)),
    .wr_data_in(REG_WDATA_IN),
    .rd_index_in(pin_index(REG_ADDR_IN)),
    .rd_data_out(pin_rdata),
    .mute_flags_out(mute_flags)
  );

  always_comb
  begin
    ctrl_next = ctrl_reg;
    cfg_next = cfg_reg;
    cko_next = cko_reg;
    den_next = den_reg;
    num_next = num_reg;
    exec_next = exec_reg;
    if (pd_active)
    begin
      ctrl_next = CLOCK_CONTROL_RESET;
      cfg_next = SYNTH_BYTE_RESET;
      cko_next = CLOCK_OUTPUT_RESET;
      den_next = {SYNTH_BYTE_RESET, SYNTH_BYTE_RESET};
      num_next = {SYNTH_BYTE_RESET, SYNTH_BYTE_RESET};
      exec_next = DSP_EXECUTE_RESET;
    end
    else if (reg_wr)
    begin
      unique case (REG_ADDR_IN)
        ADDR_CLOCK_CONTROL: ctrl_next = REG_WDATA_IN & CLOCK_CONTROL_MASK;
        ADDR_SYNTH_DEN_HIGH: den_next[15:8] = REG_WDATA_IN;
        ADDR_SYNTH_DEN_LOW: den_next[7:0] = REG_WDATA_IN;
        ADDR_SYNTH_NUM_HIGH: num_next[15:8] = REG_WDATA_IN;
        ADDR_SYNTH_NUM_LOW: num_next[7:0] = REG_WDATA_IN;
        ADDR_SYNTH_CONFIG: cfg_next = REG_WDATA_IN & SYNTH_CONFIG_MASK;
        ADDR_CLOCK_OUTPUT_CONTROL: cko_next = REG_WDATA_IN & CLOCK_OUTPUT_MASK;
        ADDR_DSP_EXECUTE_CONTROL: exec_next = REG_WDATA_IN & DSP_EXECUTE_MASK;
        default: ;
      endcase
    end
    rdata_next = '0;
    if (rd_pend_reg)
    begin
      unique case (rd_addr_reg)
        ADDR_CLOCK_CONTROL: rdata_next = ctrl_reg;
        ADDR_SYNTH_DEN_HIGH: rdata_next = den_reg[15:8];
        ADDR_SYNTH_DEN_LOW: rdata_next = den_reg[7:0];
        ADDR_SYNTH_NUM_HIGH: rdata_next = num_reg[15:8];
        ADDR_SYNTH_NUM_LOW: rdata_next = num_reg[7:0];
        ADDR_SYNTH_CONFIG: rdata_next = cfg_reg;
        ADDR_SYNTH_LOCK_STATUS: rdata_next = {7'h00, locked};
        ADDR_CLOCK_OUTPUT_CONTROL: rdata_next = cko_reg;
        ADDR_DSP_EXECUTE_CONTROL: rdata_next = exec_reg;
        default: rdata_next = in_pin_window(rd_addr_reg) ? pin_rdata : '0;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      ctrl_reg <= CLOCK_CONTROL_RESET;
      cfg_reg <= SYNTH_BYTE_RESET;
      cko_reg <= CLOCK_OUTPUT_RESET;
      den_reg <= '0;
      num_reg <= '0;
      exec_reg <= DSP_EXECUTE_RESET;
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= '0;
      REG_RDATA_OUT <= '0;
      REG_RVALID_OUT <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      cfg_reg <= cfg_next;
      cko_reg <= cko_next;
      den_reg <= den_next;
      num_reg <= num_next;
      exec_reg <= exec_next;
      rd_pend_reg <= REG_READ_IN && ready_reg && !pd_active;
      rd_addr_reg <= REG_ADDR_IN;
      REG_RDATA_OUT <= rdata_next;
      REG_RVALID_OUT <= rd_pend_reg;
    end
  end

  // Frequency synthesiser: prescaler, period lock and phase accumulator.
  ccp_synth_state_type st_reg, st_next;
  logic [1:0] pre_cnt_reg, pre_cnt_next;
  logic [PERIOD_W-1:0] per_cnt_reg, per_cnt_next;
  logic [PERIOD_W-1:0] period_reg, period_next;
  logic [PERIOD_W-1:0] period_new;
  logic [7:0] match_reg, match_next;
  logic [27:0] acc_reg, acc_next;
  logic [27:0] acc_sum;
  logic [27:0] inc;
  logic [27:0] modulus;
  logic [15:0] den_safe;
  logic div_tick;
  logic timeout;
  logic synth_tick;

  function automatic logic within_one(input logic [PERIOD_W-1:0] a,
                                      input logic [PERIOD_W-1:0] b);
    return (a >= b) ? (a - b) <= 1 : (b - a) <= 1;
  endfunction

  assign locked = (st_reg == SYNTH_LOCKED);
  assign div_tick = ref_rise && pre_cnt_reg == cfg_reg.input_divider;
  assign timeout = (per_cnt_reg == '1);
  assign period_new = per_cnt_reg + 1'b1;
  assign den_safe = (den_reg == '0) ? 16'h0001 : den_reg;
  // Half-period rate is divided reference times (R + N/M); integer mode drops N and M.
  assign inc = cfg_reg.fractional_mode ? 28'(cfg_reg.integer_part * den_safe) + 28'(num_reg)
                                       : 28'(cfg_reg.integer_part);
  assign modulus = cfg_reg.fractional_mode ? 28'(period_reg * den_safe) : 28'(period_reg);
  assign acc_sum = acc_reg + inc;

  always_comb
  begin
    st_next = st_reg;
    pre_cnt_next = pre_cnt_reg;
    per_cnt_next = timeout ? per_cnt_reg : per_cnt_reg + 1'b1;
    period_next = period_reg;
    match_next = match_reg;
    acc_next = acc_reg;
    synth_tick = 1'b0;
    if (ref_rise)
      pre_cnt_next = div_tick ? 2'b00 : pre_cnt_reg + 1'b1;
    if (div_tick)
    begin
      per_cnt_next = '0;
      period_next = period_new;
    end
    unique case (st_reg)
      SYNTH_OFF:
        if (ctrl_reg.pll_enable)
          st_next = SYNTH_ACQUIRE;
      SYNTH_ACQUIRE:
        if (div_tick)
        begin
          if (period_reg != '0 && within_one(period_new, period_reg))
          begin
            match_next = match_reg + 1'b1;
            if (match_reg == 8'(LOCK_TICKS - 1))
              st_next = SYNTH_LOCKED;
          end
          else
            match_next = '0;
        end
      SYNTH_LOCKED:
        if (timeout || (div_tick && !within_one(period_new, period_reg)))
        begin
          st_next = SYNTH_ACQUIRE;
          match_next = '0;
        end
    endcase
    // The phase step runs only on a trusted period, so a partial first period cannot flood it.
    if (locked && period_reg != '0)
    begin
      if (acc_sum >= modulus)
      begin
        acc_next = acc_sum - modulus;
        synth_tick = 1'b1;
      end
      else
        acc_next = acc_sum;
    end
    else
      acc_next = '0;
    if (timeout)
      period_next = '0;
    if (!ctrl_reg.pll_enable)
    begin
      st_next = SYNTH_OFF;
      pre_cnt_next = '0;
      per_cnt_next = '0;
      period_next = '0;
      match_next = '0;
      acc_next = '0;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      st_reg <= SYNTH_OFF;
      pre_cnt_reg <= '0;
      per_cnt_reg <= '0;
      period_reg <= '0;
      match_reg <= '0;
      acc_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
      pre_cnt_reg <= pre_cnt_next;
      per_cnt_reg <= per_cnt_next;
      period_reg <= period_next;
      match_reg <= match_next;
      acc_reg <= acc_next;
    end
  end

  // Clock tree: source select, master and core dividers, derived clock output.
  logic run;
  logic src_edge;
  logic master_edge;
  logic core_edge;
  logic cko_step;
  logic cko_allowed;
  logic mhalf_reg, mhalf_next;
  logic chalf_reg, chalf_next;
  logic master_clk_next, core_clk_next, cko_clk_next;
  logic [2:0] cko_cnt_reg, cko_cnt_next;

  function automatic logic [2:0] cko_toggle_count(input logic [2:0] factor);
    unique case (factor)
      DERIVED_CLOCK_OUTPUT_HALF: return 3'h2;
      DERIVED_CLOCK_OUTPUT_QUARTER: return 3'h4;
      DERIVED_CLOCK_OUTPUT_THIRD: return 3'h3;
      default: return 3'h1;
    endcase
  endfunction

  assign run = ready_reg && ctrl_reg.core_clock_enable;
  // Switching the source only changes which edge stream feeds the dividers.
  assign src_edge = run && (ctrl_reg.clock_source_select ? synth_tick && locked
                                                         : ref_edge);
  assign master_edge = src_edge && (ctrl_reg.master_clock_divider || mhalf_reg);
  // The core divider works on the source edges, so both fields at zero give equal clocks.
  assign core_edge = src_edge && (ctrl_reg.core_clock_divider || chalf_reg);
  assign cko_allowed = run && cko_reg.factor <= DERIVED_CLOCK_OUTPUT_THIRD
    && !(cko_reg.pdm_mode && cko_reg.factor <= DERIVED_CLOCK_OUTPUT_TIMES_ONE)
    && !(cko_reg.factor == DERIVED_CLOCK_OUTPUT_TIMES_TWO && ctrl_reg.master_clock_divider);
  assign cko_step = (cko_reg.factor == DERIVED_CLOCK_OUTPUT_TIMES_TWO) ? src_edge : master_edge;

  always_comb
  begin
    mhalf_next = src_edge ? !mhalf_reg : mhalf_reg;
    chalf_next = src_edge ? !chalf_reg : chalf_reg;
    master_clk_next = master_edge ? !MASTER_CLOCK_OUT : MASTER_CLOCK_OUT;
    core_clk_next = core_edge ? !CORE_CLOCK_OUT : CORE_CLOCK_OUT;
    cko_clk_next = DERIVED_CLOCK_OUTPUT_OUT;
    cko_cnt_next = cko_cnt_reg;
    if (cko_step)
    begin
      if (cko_cnt_reg == cko_toggle_count(cko_reg.factor) - 3'h1)
      begin
        cko_cnt_next = '0;
        cko_clk_next = !DERIVED_CLOCK_OUTPUT_OUT;
      end
      else
        cko_cnt_next = cko_cnt_reg + 3'h1;
    end
    if (!cko_allowed)
    begin
      cko_clk_next = 1'b0;
      cko_cnt_next = '0;
    end
    if (!run)
    begin
      mhalf_next = 1'b0;
      chalf_next = 1'b0;
      master_clk_next = 1'b0;
      core_clk_next = 1'b0;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      mhalf_reg <= 1'b0;
      chalf_reg <= 1'b0;
      cko_cnt_reg <= '0;
      MASTER_CLOCK_OUT <= 1'b0;
      CORE_CLOCK_OUT <= 1'b0;
      DERIVED_CLOCK_OUTPUT_OUT <= 1'b0;
      INTERNAL_READY_OUT <= 1'b0;
      SYNTH_LOCK_OUT <= 1'b0;
      DSP_RUN_OUT <= 1'b0;
      DAC_MUTE_OUT <= 1'b0;
      POWER_DOWN_OUT <= 1'b1;
    end
    else
    begin
      mhalf_reg <= mhalf_next;
      chalf_reg <= chalf_next;
      cko_cnt_reg <= cko_cnt_next;
      MASTER_CLOCK_OUT <= master_clk_next;
      CORE_CLOCK_OUT <= core_clk_next;
      DERIVED_CLOCK_OUTPUT_OUT <= cko_clk_next;
      INTERNAL_READY_OUT <= ready_reg;
      SYNTH_LOCK_OUT <= locked;
      DSP_RUN_OUT <= exec_reg[0] && run;
      DAC_MUTE_OUT <= |(mute_flags & ~mp_sync2_reg);
      POWER_DOWN_OUT <= pd_active;
    end
  end

  init_release_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    $rose(ready_reg) |-> $past(init_cnt_reg) == INIT_CNT_W'(INIT_CYCLES - 1))
    else $error("internal reset released early");
  master_gate_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    !ctrl_reg.core_clock_enable |=> !MASTER_CLOCK_OUT && !CORE_CLOCK_OUT)
    else $error("master clock runs while gated");
  div_pass_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    src_edge && ctrl_reg.master_clock_divider |=> MASTER_CLOCK_OUT != $past(MASTER_CLOCK_OUT))
    else $error("undivided master clock missed an edge");
  div_half_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    src_edge && !ctrl_reg.master_clock_divider && !mhalf_reg && ctrl_reg.core_clock_enable
    |=> $stable(MASTER_CLOCK_OUT) && mhalf_reg)
    else $error("halved master clock toggled on skipped edge");
  lock_clear_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    !ctrl_reg.pll_enable |=> !locked ##1 !SYNTH_LOCK_OUT)
    else $error("lock reported with synthesiser off");
  prescale_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    ctrl_reg.pll_enable && ref_rise && pre_cnt_reg != cfg_reg.input_divider
    |=> pre_cnt_reg == $past(pre_cnt_reg) + 2'b01)
    else $error("input divider skipped a count");
  synth_rate_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    synth_tick |-> acc_sum >= modulus && acc_next < modulus)
    else $error("synthesiser phase step wrong");
  pdm_block_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    cko_reg.pdm_mode && cko_reg.factor <= DERIVED_CLOCK_OUTPUT_TIMES_ONE |=> !DERIVED_CLOCK_OUTPUT_OUT)
    else $error("derived clock runs in PDM mode at a fast setting");
  mute_pin_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    |(mute_flags & ~mp_sync2_reg) |=> DAC_MUTE_OUT)
    else $error("mute pin did not mute the DACs");
  power_down_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    pd_active |=> !ready_reg && ctrl_reg == CLOCK_CONTROL_RESET && POWER_DOWN_OUT)
    else $error("power-down did not reset the block");

endmodule

// ===== ccp_ref_source.sv
// Reference clock source model that idles low while switched off.
`timescale 1ns/1ps
module ccp_ref_source #(
  parameter real HALF_NS = 20.345
)
(
  // Control
  input wire logic run_in,
  // Clock pin
  output logic ref_out
);
  initial ref_out = 1'b0;
  // About 24.576 MHz, unrelated in phase to the system clock.
  always
  begin
    #(HALF_NS);
    ref_out = run_in ? ~ref_out : 1'b0;
  end
endmodule

// ===== ccp_clock_top_bench.sv
// Self-checking bench for the codec clock and initialisation block.
`timescale 1ns/1ps
module ccp_clock_top_bench;
  import ccp_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, pdn = 1'b1, run = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wd = '0, rdo, v;
  logic [PIN_COUNT-1:0] mp = '1;
  logic refc, rv, mclk, cclk, dclk, rdy, lock, dsp, mute, pdo, mq, dq, rq, cq;
  int miscompares = 0, n_checks = 0, cyc = 0, nm = 0, nd = 0, nr = 0, nc = 0;
  int gm, gd, gr, gc, m0, d0, r0, c0;
  integer seed = 32'h9c0dc0a9;
  logic [DATA_W-1:0] cfg [2] = '{8'h10, 8'h22};
  always #2.5 clk = ~clk;
  ccp_ref_source src_u (.run_in(run), .ref_out(refc));
  ccp_clock_top #(.INIT_CYCLES(50), .LOCK_TICKS(4)) dut_u (.CLK_IN(clk), .RESETN_IN(rstn),
    .REG_WRITE_IN(wr), .REG_READ_IN(rd), .REG_ADDR_IN(addr), .REG_WDATA_IN(wd),
    .REG_RDATA_OUT(rdo), .REG_RVALID_OUT(rv), .REFERENCE_CLOCK_INPUT_IN(refc),
    .POWER_DOWN_PIN_N_IN(pdn), .MP_PIN_IN(mp), .MASTER_CLOCK_OUT(mclk),
    .CORE_CLOCK_OUT(cclk), .DERIVED_CLOCK_OUTPUT_OUT(dclk), .INTERNAL_READY_OUT(rdy),
    .SYNTH_LOCK_OUT(lock), .DSP_RUN_OUT(dsp), .DAC_MUTE_OUT(mute), .POWER_DOWN_OUT(pdo));
  task test_done();
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    {mq, dq, rq, cq} <= {mclk, dclk, refc, cclk};
    nm <= nm + int'(mclk !== mq);
    nc <= nc + int'(cclk !== cq);
    nd <= nd + int'(dclk !== dq);
    nr <= nr + int'(refc && !rq);
    if (cyc == 20000)
    begin
      miscompares++;
      test_done();
    end
  end
  task chk(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task chkn(string what, int exp, int got);
    n_checks++;
    if (got < exp - 3 || got > exp + 3)
    begin
      miscompares++;
      $display("BAD %s exp %0d got %0d", what, exp, got);
    end
  endtask
  task wreg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge clk);
    {wr, addr, wd} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rchk(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    d = 8'hxx;
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    repeat (4)
    begin
      @(posedge clk);
      #1;
      if (rv === 1'b1)
        d = rdo;
    end
    chk("rdata", exp, d);
  endtask
  task meas();
    {m0, d0, r0, c0} = {nm, nd, nr, nc};
    repeat (400) @(posedge clk);
    {gm, gd, gr, gc} = {nm - m0, nd - d0, nr - r0, nc - c0};
  endtask
  task waitrdy();
    for (int i = 0; i < 200 && rdy !== 1'b1; i++)
      @(posedge clk);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    run <= 1'b1;
    repeat (40) @(posedge clk);
    chk("ready", 8'h00, {7'h0, rdy});
    waitrdy();
    chk("ready", 8'h01, {7'h0, rdy});
    rchk(ADDR_CLOCK_CONTROL, CLOCK_CONTROL_RESET);
    rchk(ADDR_CLOCK_OUTPUT_CONTROL, CLOCK_OUTPUT_RESET);
    rchk(16'h0008, 8'h00);
    for (int a = 1; a < 5; a++)
    begin
      v = 8'($random(seed));
      wreg(a[ADDR_W-1:0], v);
      rchk(a[ADDR_W-1:0], v);
    end
    wreg(ADDR_SYNTH_LOCK_STATUS, 8'hff);
    rchk(ADDR_SYNTH_LOCK_STATUS, 8'h00);
    v = 8'($random(seed));
    wreg(ADDR_CLOCK_CONTROL, v & 8'h76);
    rchk(ADDR_CLOCK_CONTROL, v & 8'h76 & CLOCK_CONTROL_MASK);
    wreg(ADDR_CLOCK_CONTROL, 8'h06);
    meas();
    chkn("gated", 0, gm);
    wreg(ADDR_CLOCK_CONTROL, 8'h07);
    meas();
    chkn("div1", 2 * gr, gm);
    chkn("core1", 2 * gr, gc);
    wreg(ADDR_CLOCK_CONTROL, 8'h01);
    wreg(ADDR_CLOCK_OUTPUT_CONTROL, 8'h08);
    meas();
    chkn("div2", gr, gm);
    chkn("core2", gr, gc);
    chkn("pdm x2", 0, gd);
    wreg(ADDR_CLOCK_OUTPUT_CONTROL, 8'h0a);
    meas();
    chkn("half", gr / 2, gd);
    for (int k = 0; k < 2; k++)
    begin
      wreg(ADDR_CLOCK_CONTROL, 8'h00);
      wreg(ADDR_SYNTH_CONFIG, cfg[k]);
      wreg(ADDR_CLOCK_CONTROL, 8'h80);
      for (int i = 0; i < 300 && lock !== 1'b1; i++)
        @(posedge clk);
      rchk(ADDR_SYNTH_LOCK_STATUS, 8'h01);
      wreg(ADDR_CLOCK_CONTROL, 8'h89);
      meas();
      chkn("synth", gr, gm);
      chkn("synth core", gr, gc);
    end
    wreg(ADDR_DSP_EXECUTE_CONTROL, 8'h01);
    repeat (3) @(posedge clk);
    chk("run", 8'h01, {7'h0, dsp});
    wreg(ADDR_DSP_EXECUTE_CONTROL, 8'h00);
    repeat (3) @(posedge clk);
    chk("run", 8'h00, {7'h0, dsp});
    wreg(ADDR_CLOCK_CONTROL, 8'h09);
    repeat (3) @(posedge clk);
    chk("lock", 8'h00, {7'h0, lock});
    wreg(ADDR_PIN_MODE_FIRST, PIN_MODE_MUTE_DACS);
    mp[0] <= 1'b0;
    repeat (6) @(posedge clk);
    chk("mute", 8'h01, {7'h0, mute});
    pdn <= 1'b0;
    repeat (5) @(posedge clk);
    chk("pdown", 8'h01, {7'h0, pdo});
    chk("mclk", 8'h00, {7'h0, mclk});
    pdn <= 1'b1;
    waitrdy();
    rchk(ADDR_CLOCK_CONTROL, CLOCK_CONTROL_RESET);
    chk("mute", 8'h00, {7'h0, mute});
    test_done();
  end
endmodule
